// File: hw/eac_ctrl.sv
// cpu-side access controller for the nonvolatile byte store
`timescale 1ns/1ps
`default_nettype none
module eac_ctrl #(
  parameter int ADDR_W = eac_pkg::ADDR_W,
  parameter int CYC_ATOMIC = eac_pkg::CYC_ATOMIC,
  parameter int CYC_SPLIT = eac_pkg::CYC_SPLIT
) (
  input wire logic clk_in,
  input wire logic resetn_in,
  input wire eac_pkg::eac_io_req_t io_req_in,
  input wire logic global_irq_en_in,
  input wire logic code_store_busy_in,
  output logic [7:0] io_rdata_out,
  output logic cpu_stall_out,
  output logic ready_irq_out
);
  localparam logic [eac_pkg::CNT_W-1:0] ATOMIC_CNT = eac_pkg::CNT_W'(CYC_ATOMIC);
  localparam logic [eac_pkg::CNT_W-1:0] SPLIT_CNT = eac_pkg::CNT_W'(CYC_SPLIT);

  eac_pkg::eac_state_t state_q, state_d;
  logic [eac_pkg::CNT_W-1:0] prog_cnt_q, prog_cnt_d;
  logic [1:0] mode_q, mode_d;
  logic rie_q;
  logic [2:0] arm_cnt_q, arm_cnt_d;
  logic [2:0] stall_cnt_q, stall_cnt_d;
  logic stall_q;
  logic irq_q;
  logic [ADDR_W-1:0] addr_q;
  logic [7:0] data_q;
  logic rd_pend_q;
  logic [7:0] rdata_q;
  logic [7:0] arr_rdata;

  // decode
  wire wr_ctrl = io_req_in.wr && (io_req_in.addr == eac_pkg::OFS_CTRL);
  wire wr_data = io_req_in.wr && (io_req_in.addr == eac_pkg::OFS_DATA);
  wire wr_alo = io_req_in.wr && (io_req_in.addr == eac_pkg::OFS_ADDR_LO);
  wire wr_ahi = io_req_in.wr && (io_req_in.addr == eac_pkg::OFS_ADDR_HI);
  wire busy = (state_q != eac_pkg::EAC_IDLE);
  wire armed = (arm_cnt_q != 3'h0);
  wire set_arm = wr_ctrl && io_req_in.wdata[eac_pkg::BIT_ARM];
  wire set_strobe = wr_ctrl && io_req_in.wdata[eac_pkg::BIT_STROBE];
  wire set_read = wr_ctrl && io_req_in.wdata[eac_pkg::BIT_READ];
  // an unarmed strobe or the reserved action starts nothing
  wire start = set_strobe && armed && !busy && (mode_d != eac_pkg::MODE_RSVD);
  wire rd_go = set_read && !busy;
  wire prog_done = (state_q == eac_pkg::EAC_PROG) && (prog_cnt_q == eac_pkg::CNT_W'(1));
  wire [7:0] ctrl_rd = {2'b00, mode_q, rie_q, armed, busy, 1'b0};
  wire [15:0] addr_rd = {{(16 - ADDR_W){1'b0}}, addr_q};
  wire [7:0] rd_mux = (io_req_in.addr == eac_pkg::OFS_CTRL) ? ctrl_rd :
                      (io_req_in.addr == eac_pkg::OFS_DATA) ? data_q :
                      (io_req_in.addr == eac_pkg::OFS_ADDR_LO) ? addr_rd[7:0] :
                      (io_req_in.addr == eac_pkg::OFS_ADDR_HI) ? addr_rd[15:8] : 8'h00;

  // action select only moves while no operation is pending
  assign mode_d = (wr_ctrl && !busy) ?
                  io_req_in.wdata[eac_pkg::BIT_MODE_HI:eac_pkg::BIT_MODE_LO] : mode_q;

  always_comb
  begin
    state_d = state_q;
    prog_cnt_d = prog_cnt_q;
    case (state_q)
      eac_pkg::EAC_IDLE:
      begin
        if (start)
        begin
          state_d = eac_pkg::EAC_WAIT_CODE;
        end
      end
      eac_pkg::EAC_WAIT_CODE:
      begin
        // held back until the code store has finished its own write
        if (!code_store_busy_in)
        begin
          state_d = eac_pkg::EAC_PROG;
          prog_cnt_d = (mode_q == eac_pkg::MODE_ATOMIC) ? ATOMIC_CNT : SPLIT_CNT;
        end
      end
      eac_pkg::EAC_PROG:
      begin
        prog_cnt_d = prog_cnt_q - 1'b1;
        if (prog_done)
        begin
          state_d = eac_pkg::EAC_IDLE;
        end
      end
      default:
      begin
        state_d = eac_pkg::EAC_IDLE;
      end
    endcase
  end

  assign arm_cnt_d = set_arm ? eac_pkg::ARM_CYC :
                     armed ? (arm_cnt_q - 3'h1) : 3'h0;
  assign stall_cnt_d = start ? eac_pkg::WR_STALL_CYC :
                       rd_go ? eac_pkg::RD_STALL_CYC :
                       (stall_cnt_q != 3'h0) ? (stall_cnt_q - 3'h1) : 3'h0;

  // a running operation survives reset so the cell is never left half done
  always_ff @(posedge clk_in)
  begin
    if (!resetn_in && (state_q != eac_pkg::EAC_PROG))
    begin
      state_q <= eac_pkg::EAC_IDLE;
      prog_cnt_q <= '0;
      mode_q <= eac_pkg::MODE_RESET;
    end
    else if (!resetn_in)
    begin
      state_q <= state_d;
      prog_cnt_q <= prog_cnt_d;
    end
    else
    begin
      state_q <= state_d;
      prog_cnt_q <= prog_cnt_d;
      mode_q <= mode_d;
    end
  end

  always_ff @(posedge clk_in)
  begin
    if (!resetn_in)
    begin
      rie_q <= eac_pkg::RIE_RESET;
      arm_cnt_q <= 3'h0;
      stall_cnt_q <= 3'h0;
      stall_q <= 1'b0;
      irq_q <= 1'b0;
      rd_pend_q <= 1'b0;
      rdata_q <= 8'h00;
    end
    else
    begin
      if (wr_ctrl)
      begin
        rie_q <= io_req_in.wdata[eac_pkg::BIT_RIE];
      end
      arm_cnt_q <= arm_cnt_d;
      stall_cnt_q <= stall_cnt_d;
      stall_q <= (stall_cnt_d != 3'h0);
      irq_q <= !busy && rie_q && global_irq_en_in;
      rd_pend_q <= rd_go;
      if (io_req_in.rd)
      begin
        rdata_q <= rd_mux;
      end
    end
  end

  // address held while an operation is pending; data left open
  always_ff @(posedge clk_in)
  begin
    if (resetn_in && wr_alo && !busy)
    begin
      addr_q[7:0] <= io_req_in.wdata;
    end
    if (resetn_in && wr_ahi && !busy)
    begin
      addr_q[ADDR_W-1:8] <= io_req_in.wdata[ADDR_W-9:0];
    end
    if (rd_pend_q)
    begin
      data_q <= arr_rdata;
    end
    else if (resetn_in && wr_data)
    begin
      data_q <= io_req_in.wdata;
    end
  end

  eac_array #(
    .ADDR_W(ADDR_W),
    .DATA_W(eac_pkg::DATA_W)
  ) u_array (
    .clk_in(clk_in),
    .wr_en_in(prog_done),
    .wr_mode_in(mode_q),
    .rd_en_in(rd_go),
    .addr_in(addr_q),
    .wdata_in(data_q),
    .rdata_out(arr_rdata)
  );

  assign io_rdata_out = rdata_q;
  assign cpu_stall_out = stall_q;
  assign ready_irq_out = irq_q;

  // checks
  property p_arm_life;
    @(posedge clk_in) disable iff (!resetn_in)
    set_arm |=> armed [*4] ##1
      (!armed || $past(set_arm) || $past(set_arm, 2) || $past(set_arm, 3) || $past(set_arm, 4));
  endproperty
  a_arm_life: assert property (p_arm_life) else $error("arm bit life wrong");

  property p_no_arm_no_start;
    @(posedge clk_in) disable iff (!resetn_in)
    (set_strobe && !armed && !busy) |=> !busy;
  endproperty
  a_no_arm_no_start: assert property (p_no_arm_no_start) else $error("unarmed start");

  property p_mode_frozen;
    @(posedge clk_in) disable iff (!resetn_in)
    busy |=> $stable(mode_q);
  endproperty
  a_mode_frozen: assert property (p_mode_frozen) else $error("mode changed while busy");

  property p_addr_frozen;
    @(posedge clk_in) disable iff (!resetn_in)
    busy |=> $stable(addr_q);
  endproperty
  a_addr_frozen: assert property (p_addr_frozen) else $error("address changed while busy");

  property p_irq_level;
    @(posedge clk_in) disable iff (!resetn_in)
    (!busy && rie_q && global_irq_en_in) |=> ready_irq_out;
  endproperty
  a_irq_level: assert property (p_irq_level) else $error("ready irq missing");

  property p_irq_off;
    @(posedge clk_in) disable iff (!resetn_in)
    busy |=> !ready_irq_out;
  endproperty
  a_irq_off: assert property (p_irq_off) else $error("ready irq while busy");

  property p_wr_stall;
    @(posedge clk_in) disable iff (!resetn_in)
    start |=> cpu_stall_out [*2] ##1 !cpu_stall_out;
  endproperty
  a_wr_stall: assert property (p_wr_stall) else $error("write stall length");

  property p_rd_stall;
    @(posedge clk_in) disable iff (!resetn_in)
    (rd_go && !start) |=> cpu_stall_out [*4] ##1 (!cpu_stall_out || $past(rd_go));
  endproperty
  a_rd_stall: assert property (p_rd_stall) else $error("read stall length");

  property p_rd_load;
    @(posedge clk_in) disable iff (!resetn_in)
    rd_go |=> ##1 (data_q == $past(arr_rdata));
  endproperty
  a_rd_load: assert property (p_rd_load) else $error("read data not loaded");

  property p_code_hold;
    @(posedge clk_in) disable iff (!resetn_in)
    (state_q == eac_pkg::EAC_WAIT_CODE && code_store_busy_in) |=> state_q != eac_pkg::EAC_PROG;
  endproperty
  a_code_hold: assert property (p_code_hold) else $error("programmed during code write");

  property p_strobe_busy;
    @(posedge clk_in) disable iff (!resetn_in)
    (start || (busy && !prog_done)) |=> ctrl_rd[eac_pkg::BIT_STROBE];
  endproperty
  a_strobe_busy: assert property (p_strobe_busy) else $error("strobe not reading busy");

  property p_done_idle;
    @(posedge clk_in) disable iff (!resetn_in)
    prog_done |=> !busy;
  endproperty
  a_done_idle: assert property (p_done_idle) else $error("strobe not cleared at end");

  property p_addr_top;
    @(posedge clk_in) disable iff (!resetn_in)
    (io_req_in.rd && (io_req_in.addr == eac_pkg::OFS_ADDR_HI)) |=>
      (io_rdata_out[7:1] == 7'h00);
  endproperty
  a_addr_top: assert property (p_addr_top) else $error("upper address set");

  property p_strobe_read;
    @(posedge clk_in) disable iff (!resetn_in)
    (io_req_in.rd && (io_req_in.addr == eac_pkg::OFS_CTRL)) |=>
      (io_rdata_out[eac_pkg::BIT_STROBE] == $past(busy));
  endproperty
  a_strobe_read: assert property (p_strobe_read) else $error("strobe read not busy");

  property p_reset_mode;
    @(posedge clk_in)
    (!resetn_in && (state_q != eac_pkg::EAC_PROG)) |=> (mode_q == eac_pkg::MODE_RESET);
  endproperty
  a_reset_mode: assert property (p_reset_mode) else $error("action select not reset");

  property p_reset_keep;
    @(posedge clk_in)
    (!resetn_in && (state_q == eac_pkg::EAC_PROG) && !prog_done) |=>
      ((state_q == eac_pkg::EAC_PROG) && $stable(mode_q));
  endproperty
  a_reset_keep: assert property (p_reset_keep) else $error("reset aborted programming");

  property p_read_refused;
    @(posedge clk_in) disable iff (!resetn_in)
    (set_read && busy) |=> !rd_pend_q;
  endproperty
  a_read_refused: assert property (p_read_refused) else $error("read while busy");

  property p_rsvd_idle;
    @(posedge clk_in) disable iff (!resetn_in)
    (set_strobe && armed && !busy && (mode_d == eac_pkg::MODE_RSVD)) |=> !busy;
  endproperty
  a_rsvd_idle: assert property (p_rsvd_idle) else $error("reserved action started");

  property p_cnt_load;
    @(posedge clk_in) disable iff (!resetn_in)
    ((state_q == eac_pkg::EAC_WAIT_CODE) && !code_store_busy_in) |=>
      (prog_cnt_q == ((mode_q == eac_pkg::MODE_ATOMIC) ? ATOMIC_CNT : SPLIT_CNT));
  endproperty
  a_cnt_load: assert property (p_cnt_load) else $error("wrong operation length");

  property p_arm_off;
    @(posedge clk_in) disable iff (!resetn_in)
    (!armed && !set_arm) |=> !armed;
  endproperty
  a_arm_off: assert property (p_arm_off) else $error("arm set by itself");

  property p_data_load;
    @(posedge clk_in) disable iff (!resetn_in)
    (wr_data && !rd_pend_q) |=> (data_q == $past(io_req_in.wdata));
  endproperty
  a_data_load: assert property (p_data_load) else $error("data write lost");

  property p_addr_load;
    @(posedge clk_in) disable iff (!resetn_in)
    (wr_alo && !busy) |=> (addr_q[7:0] == $past(io_req_in.wdata));
  endproperty
  a_addr_load: assert property (p_addr_load) else $error("address write lost");

  property p_irq_masked;
    @(posedge clk_in) disable iff (!resetn_in)
    !rie_q |=> !ready_irq_out;
  endproperty
  a_irq_masked: assert property (p_irq_masked) else $error("ready irq while disabled");

  property p_cnt_down;
    @(posedge clk_in)
    ((state_q == eac_pkg::EAC_PROG) && !prog_done) |=>
      (prog_cnt_q == ($past(prog_cnt_q) - 1'b1));
  endproperty
  a_cnt_down: assert property (p_cnt_down) else $error("operation timer stuck");
endmodule
`default_nettype wire

// File: include/eac_pkg.sv
// shared constants and types for the byte-wide nonvolatile store controller
package eac_pkg;
  localparam int ADDR_W = 9;
  localparam int DATA_W = 8;
  localparam int IO_W = 6;
  localparam int CNT_W = 16;

  // i/o register locations
  localparam logic [IO_W-1:0] OFS_CTRL = 6'h1F;
  localparam logic [IO_W-1:0] OFS_DATA = 6'h20;
  localparam logic [IO_W-1:0] OFS_ADDR_LO = 6'h21;
  localparam logic [IO_W-1:0] OFS_ADDR_HI = 6'h22;

  // control register field positions
  localparam int BIT_READ = 0;
  localparam int BIT_STROBE = 1;
  localparam int BIT_ARM = 2;
  localparam int BIT_RIE = 3;
  localparam int BIT_MODE_LO = 4;
  localparam int BIT_MODE_HI = 5;

  localparam logic [1:0] MODE_ATOMIC = 2'h0;
  localparam logic [1:0] MODE_ERASE = 2'h1;
  localparam logic [1:0] MODE_WRITE = 2'h2;
  localparam logic [1:0] MODE_RSVD = 2'h3;
  localparam logic [1:0] MODE_RESET = 2'h0;
  localparam logic [7:0] ERASED_BYTE = 8'hFF;
  localparam logic RIE_RESET = 1'b0;

  // timing
  localparam int CLK_PERIOD_NS = 100;
  localparam int T_ATOMIC_NS = 3_400_000;
  localparam int T_SPLIT_NS = 1_800_000;
  localparam int CYC_ATOMIC = (T_ATOMIC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CYC_SPLIT = (T_SPLIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [2:0] ARM_CYC = 3'h4;
  localparam logic [2:0] WR_STALL_CYC = 3'h2;
  localparam logic [2:0] RD_STALL_CYC = 3'h4;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [IO_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } eac_io_req_t;

  typedef enum logic [1:0] {
    EAC_IDLE,
    EAC_WAIT_CODE,
    EAC_PROG
  } eac_state_t;
endpackage

// File: hw/eac_array.sv
// byte array with registered read and three programming actions
`timescale 1ns/1ps
`default_nettype none
module eac_array #(
  parameter int ADDR_W = eac_pkg::ADDR_W,
  parameter int DATA_W = eac_pkg::DATA_W
) (
  input wire logic clk_in,
  input wire logic wr_en_in,
  input wire logic [1:0] wr_mode_in,
  input wire logic rd_en_in,
  input wire logic [ADDR_W-1:0] addr_in,
  input wire logic [DATA_W-1:0] wdata_in,
  output logic [DATA_W-1:0] rdata_out
);
  logic [DATA_W-1:0] mem_q [0:(1<<ADDR_W)-1];
  logic [DATA_W-1:0] old_w;
  logic [DATA_W-1:0] new_w;

  assign old_w = mem_q[addr_in];
  // write-only can only clear bits, so it merges with the old content
  assign new_w = (wr_mode_in == eac_pkg::MODE_ERASE) ? eac_pkg::ERASED_BYTE :
                 (wr_mode_in == eac_pkg::MODE_WRITE) ? (old_w & wdata_in) : wdata_in;

  always_ff @(posedge clk_in)
  begin
    if (wr_en_in)
    begin
      mem_q[addr_in] <= new_w;
    end
  end

  always_ff @(posedge clk_in)
  begin
    if (rd_en_in)
    begin
      rdata_out <= old_w;
    end
  end
endmodule
`default_nettype wire

// File: tb/test_eac_ctrl.sv
// self-checking bench for the nonvolatile byte store controller
`timescale 1ns/1ps
`default_nettype none
module test_eac_ctrl;
  logic clk_in = 1'b0;
  logic resetn = 1'b0;
  logic gie = 1'b0;
  logic csb = 1'b0;
  eac_pkg::eac_io_req_t req = '0;
  logic [7:0] rdata;
  logic stall;
  logic irq;
  int err_count = 0;
  int checks = 0;
  logic [7:0] v;
  // short operation counts keep the run small
  eac_ctrl #(.CYC_ATOMIC(20), .CYC_SPLIT(10)) eac_ctrl_i (
    .clk_in(clk_in),
    .resetn_in(resetn),
    .io_req_in(req),
    .global_irq_en_in(gie),
    .code_store_busy_in(csb),
    .io_rdata_out(rdata),
    .cpu_stall_out(stall),
    .ready_irq_out(irq)
  );
  always #50 clk_in = ~clk_in;
  task automatic conclude();
    $display("mismatches %0d, comparisons %0d", err_count, checks);
    if (err_count == 0 && checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp)
    begin
      err_count++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    @(posedge clk_in);
    req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge clk_in);
    req.wr <= 1'b0;
  endtask
  task automatic rd(input logic [5:0] a, output logic [7:0] d);
    @(posedge clk_in);
    req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge clk_in);
    req.rd <= 1'b0;
    @(posedge clk_in);
    #1 d = rdata;
  endtask
  // counts stall cycles in the eight cycles after a control write
  task automatic stall_len(input int exp);
    int n;
    n = 0;
    repeat (8)
    begin
      #1 if (stall === 1'b1) n++;
      @(posedge clk_in);
    end
    chk(8'(n), 8'(exp));
  endtask
  task automatic wait_idle();
    for (int i = 0; i < 100; i++)
    begin
      rd(eac_pkg::OFS_CTRL, v);
      if (v[1] === 1'b0) return;
    end
    err_count++;
    $display("CHECK FAILED at %0t: strobe never cleared", $time);
    conclude();
  endtask
  task automatic prog(input logic [1:0] m, input logic [8:0] a, input logic [7:0] d);
    wr(eac_pkg::OFS_ADDR_LO, a[7:0]);
    wr(eac_pkg::OFS_ADDR_HI, {7'h00, a[8]});
    wr(eac_pkg::OFS_DATA, d);
    wr(eac_pkg::OFS_CTRL, {2'h0, m, 4'h4});
    wr(eac_pkg::OFS_CTRL, {2'h0, m, 4'h2});
  endtask
  task automatic fetch(input logic [8:0] a, input logic [7:0] exp);
    wr(eac_pkg::OFS_ADDR_LO, a[7:0]);
    wr(eac_pkg::OFS_ADDR_HI, {7'h00, a[8]});
    wr(eac_pkg::OFS_CTRL, 8'h01);
    stall_len(4);
    rd(eac_pkg::OFS_DATA, v);
    chk(v, exp);
  endtask
  task automatic s_reset();
    rd(eac_pkg::OFS_CTRL, v);
    chk(v, 8'h00);
    wr(eac_pkg::OFS_ADDR_HI, 8'hFF);
    rd(eac_pkg::OFS_ADDR_HI, v);
    chk(v, 8'h01);
    wr(eac_pkg::OFS_DATA, 8'hA5);
    rd(eac_pkg::OFS_DATA, v);
    chk(v, 8'hA5);
  endtask
  task automatic s_modes();
    prog(eac_pkg::MODE_ATOMIC, 9'h105, 8'h5A);
    stall_len(2);
    wr(eac_pkg::OFS_ADDR_LO, 8'h00);
    wr(eac_pkg::OFS_CTRL, 8'h32);
    rd(eac_pkg::OFS_CTRL, v);
    chk(v, 8'h02);
    wait_idle();
    fetch(9'h105, 8'h5A);
    prog(eac_pkg::MODE_ERASE, 9'h105, 8'h00);
    wr(eac_pkg::OFS_CTRL, 8'h03);
    stall_len(0);
    wait_idle();
    fetch(9'h105, eac_pkg::ERASED_BYTE);
    prog(eac_pkg::MODE_WRITE, 9'h105, 8'h3C);
    wait_idle();
    fetch(9'h105, 8'h3C);
    prog(eac_pkg::MODE_WRITE, 9'h105, 8'hF0);
    wait_idle();
    fetch(9'h105, 8'h30);
  endtask
  task automatic s_refuse();
    wr(eac_pkg::OFS_CTRL, 8'h02);
    rd(eac_pkg::OFS_CTRL, v);
    chk(v, 8'h00);
    wr(eac_pkg::OFS_CTRL, 8'h04);
    rd(eac_pkg::OFS_CTRL, v);
    chk(v, 8'h04);
    repeat (6) @(posedge clk_in);
    wr(eac_pkg::OFS_CTRL, 8'h02);
    rd(eac_pkg::OFS_CTRL, v);
    chk(v, 8'h00);
    // reserved action select never starts an operation
    wr(eac_pkg::OFS_CTRL, 8'h34);
    wr(eac_pkg::OFS_CTRL, 8'h32);
    rd(eac_pkg::OFS_CTRL, v);
    // arm still live on this read, select kept at reserved
    chk(v, 8'h34);
    fetch(9'h105, 8'h30);
  endtask
  task automatic s_code();
    @(posedge clk_in);
    csb <= 1'b1;
    prog(eac_pkg::MODE_ATOMIC, 9'h0AA, 8'h11);
    repeat (40) @(posedge clk_in);
    rd(eac_pkg::OFS_CTRL, v);
    chk({7'h00, v[1]}, 8'h01);
    @(posedge clk_in);
    csb <= 1'b0;
    wait_idle();
    fetch(9'h0AA, 8'h11);
  endtask
  task automatic s_irq();
    @(posedge clk_in);
    gie <= 1'b1;
    wr(eac_pkg::OFS_CTRL, 8'h08);
    repeat (2) @(posedge clk_in);
    #1 chk({7'h00, irq}, 8'h01);
    @(posedge clk_in);
    gie <= 1'b0;
    repeat (2) @(posedge clk_in);
    #1 chk({7'h00, irq}, 8'h00);
    // global enable stays low across the timed arm and strobe pair
    wr(eac_pkg::OFS_CTRL, 8'h0C);
    wr(eac_pkg::OFS_CTRL, 8'h0A);
    gie <= 1'b1;
    repeat (2) @(posedge clk_in);
    #1 chk({7'h00, irq}, 8'h00);
    wait_idle();
    #1 chk({7'h00, irq}, 8'h01);
    wr(eac_pkg::OFS_CTRL, 8'h00);
    gie <= 1'b0;
  endtask
  task automatic s_reset_mid();
    prog(eac_pkg::MODE_WRITE, 9'h0AA, 8'h01);
    repeat (2) @(posedge clk_in);
    resetn <= 1'b0;
    repeat (3) @(posedge clk_in);
    resetn <= 1'b1;
    rd(eac_pkg::OFS_CTRL, v);
    chk(v, 8'h22);
    wait_idle();
    chk(v, 8'h20);
    fetch(9'h0AA, 8'h01);
    wr(eac_pkg::OFS_CTRL, 8'h28);
    resetn <= 1'b0;
    repeat (2) @(posedge clk_in);
    resetn <= 1'b1;
    rd(eac_pkg::OFS_CTRL, v);
    chk(v, 8'h00);
  endtask
  initial
  begin
    repeat (20) @(posedge clk_in);
    resetn <= 1'b1;
    s_reset();
    s_modes();
    s_refuse();
    s_code();
    s_irq();
    s_reset_mid();
    conclude();
  end
endmodule
`default_nettype wire
